// ---- logic/pi_mode_switch_feedforward.sv ----
`timescale 1ns/1ps
// Operation
// R1: feed-forward select 0 disables path; 1 routes analog speed input.
// R2: gain 150..3000 in 0.01 V/rated speed, default 600, immediate.
// R3: analog feed-forward applies only in position control mode.
// R4: 6 V at default gain is rated speed; contribution limited to rated.
// R5: host differentiates position reference and sends it with pulses.
// R6: in speed or position control, prop-only input selects PI or P.
// R7: input high means PI, low means P; host drives it.
// R8: auto switch select: 0 torque, 1 speed, 2 accel, 3 error, 4 off.
// R9: torque mode: P when torque reference exceeds level, default 200 %.
// R10: speed mode: P when speed reference exceeds rpm level.
// R11: accel mode: P when acceleration exceeds level in 10 rpm/s.
// R12: error mode: P when error pulse count exceeds level.
// R13: error mode acts only in position control.
// R14: auto switch compares internal quantity; no external input.
// R15: back to PI once quantity no longer exceeds level; magnitudes.
module pi_mode_switch_feedforward
  import pi_mode_pkg::*;
(
  input  wire logic                    clock,            // 50 MHz
  input  wire logic                    rst,              // sync, high
  input  wire logic [1:0]              speed_ff_select_field, // ff mode
  input  wire logic [GAIN_W-1:0]       speed_input_gain_setting, // gain
  input  wire logic [1:0]              control_mode_select_field, // mode
  input  wire logic [2:0]              auto_switch_select_field, // detect
  input  wire pi_mode_pkg::switch_levels_t levels,       // detect levels
  input  wire pi_mode_pkg::servo_values_t  values,       // servo values
  input  wire logic [SPEED_W-1:0]      rated_speed,      // rpm
  input  wire logic signed [AIN_W-1:0] speed_ain,        // 0.01 V units
  input  wire logic                    prop_only_request_input_n, // pin
  output logic signed [SPEED_W-1:0]    ff_speed,         // rpm
  output logic                         p_control,        // 1 = P loop
  output logic                         auto_p_active,    // auto switch
  output logic                         gain_in_range     // gain legal
);
  import pi_mode_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             pin_s1;      // synchroniser stage one
    logic             pin_s2;      // synchroniser stage two
    logic             p_ctrl;
    logic             auto_p;
    logic             gain_ok;
    logic [GAIN_W-1:0] gain;       // effective gain
  } state_t;

  state_t s_q, s_d;

  logic                 pos_mode;
  logic                 ff_en;
  logic [3:0]           over;
  logic                 auto_hit;
  logic                 manual_sel;
  logic                 gain_legal;
  switch_sel_t          sel;
  logic signed [SPEED_W-1:0] ff_raw;

  assign pos_mode = control_mode_select_field == CTRL_POS;
  assign sel      = switch_sel_t'(auto_switch_select_field);

  // ---------------------------------------------------------------
  // feed-forward path
  // ---------------------------------------------------------------
  // path only runs in position control with the analog input chosen
  assign ff_en = (speed_ff_select_field == FF_VREF) && pos_mode; // [R1] [R3]

  pi_ff_scaler u_ff (
    .clock       (clock),
    .rst         (rst),
    .enable      (ff_en),
    .ain         (speed_ain),
    .gain        (s_q.gain),
    .rated_speed (rated_speed),
    .ff_speed    (ff_raw)
  );

  // ---------------------------------------------------------------
  // level detectors, one per detectable quantity
  // ---------------------------------------------------------------
  logic signed [VAL_W-1:0] vals [4];
  logic        [VAL_W-1:0] lvls [4];
  assign vals[0] = values.torque_ref;   // [R9]
  assign vals[1] = values.speed_ref;    // [R10]
  assign vals[2] = values.accel;        // [R11]
  assign vals[3] = values.pos_error;    // [R12]
  assign lvls[0] = levels.torque_lvl;
  assign lvls[1] = levels.speed_lvl;
  assign lvls[2] = levels.accel_lvl;
  assign lvls[3] = levels.error_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_det
      pi_level_detect #(.W(VAL_W)) u_det (
        .clock (clock),
        .rst   (rst),
        .value (vals[gi]),
        .level (lvls[gi]),
        .over  (over[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // auto switch select decode
  // ---------------------------------------------------------------
  // purely internal quantities; the external pin plays no part here
  always_comb begin
    auto_hit = 1'b0;                                  // [R14]
    unique case (sel)                                 // [R8]
      SW_TORQUE: auto_hit = over[0];                  // [R9]
      SW_SPEED:  auto_hit = over[1];                  // [R10]
      SW_ACCEL:  auto_hit = over[2];                  // [R11]
      SW_ERROR:  auto_hit = over[3] && pos_mode;      // [R12] [R13]
      SW_OFF:    auto_hit = 1'b0;
      default:   auto_hit = 1'b0;                     // codes 5..7 unused
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // the manual pin only counts in speed or position control
  assign manual_sel = (control_mode_select_field == CTRL_SPEED ||
                       pos_mode) && !s_q.pin_s2;      // [R6] [R7]
  assign gain_legal = speed_input_gain_setting >= GAIN_MIN &&
                      speed_input_gain_setting <= GAIN_MAX;

  always_comb begin
    s_d         = s_q;
    s_d.pin_s1  = prop_only_request_input_n;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.auto_p  = auto_hit;                           // [R15]
    s_d.p_ctrl  = manual_sel || auto_hit;             // [R7]
    s_d.gain_ok = gain_legal;
    // an out-of-range write is ignored; last legal gain stays in use
    if (gain_legal) begin
      s_d.gain = speed_input_gain_setting;            // [R2]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q         <= '0;
      s_q.pin_s1  <= 1'b1;
      s_q.pin_s2  <= 1'b1;
      s_q.gain_ok <= 1'b1;
      s_q.gain    <= GAIN_RESET;                      // [R2]
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ff_speed      = ff_raw;
  assign p_control     = s_q.p_ctrl;
  assign auto_p_active = s_q.auto_p;
  assign gain_in_range = s_q.gain_ok;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ff_pos_only;
    @(posedge clock) disable iff (rst)
      !pos_mode |=> ff_speed == 0;
  endproperty
  a_ff_pos_only: assert property (p_ff_pos_only) // [R3]
    else $error("feed-forward outside position control");

  property p_pin_low_p;
    @(posedge clock) disable iff (rst)
      (!prop_only_request_input_n && control_mode_select_field == CTRL_SPEED)
        [*3] |=> p_control;
  endproperty
  a_pin_low_p: assert property (p_pin_low_p) // [R7]
    else $error("pin low did not give P control");

  property p_pi_when_clear;
    @(posedge clock) disable iff (rst)
      (prop_only_request_input_n && sel == SW_OFF) [*3] |=> !p_control;
  endproperty
  a_pi_when_clear: assert property (p_pi_when_clear) // [R6]
    else $error("P control without cause");

  property p_off_no_auto;
    @(posedge clock) disable iff (rst)
      sel == SW_OFF |=> !auto_p_active;
  endproperty
  a_off_no_auto: assert property (p_off_no_auto) // [R8]
    else $error("auto switch while disabled");

  property p_torque_trip;
    @(posedge clock) disable iff (rst)
      (sel == SW_TORQUE && over[0]) |=> auto_p_active && p_control;
  endproperty
  a_torque_trip: assert property (p_torque_trip) // [R9]
    else $error("torque level did not switch to P");

  property p_error_pos;
    @(posedge clock) disable iff (rst)
      (sel == SW_ERROR && !pos_mode) |=> !auto_p_active;
  endproperty
  a_error_pos: assert property (p_error_pos) // [R13]
    else $error("error mode switched outside position control");

  property p_speed_trip;
    @(posedge clock) disable iff (rst)
      (sel == SW_SPEED && over[1]) |=> auto_p_active;
  endproperty
  a_speed_trip: assert property (p_speed_trip) // [R10]
    else $error("speed level did not switch to P");

  property p_accel_release;
    @(posedge clock) disable iff (rst)
      (sel == SW_ACCEL && !over[2]) |=> !auto_p_active;
  endproperty
  a_accel_release: assert property (p_accel_release) // [R15]
    else $error("auto switch held after level cleared");

  property p_gain_kept;
    @(posedge clock) disable iff (rst)
      !gain_legal |=> s_q.gain == $past(s_q.gain);
  endproperty
  a_gain_kept: assert property (p_gain_kept) // [R2]
    else $error("illegal gain accepted");

  property p_gain_take;
    @(posedge clock) disable iff (rst)
      gain_legal |=> s_q.gain == $past(speed_input_gain_setting);
  endproperty
  a_gain_take: assert property (p_gain_take) // [R2]
    else $error("legal gain not taken");

  property p_gain_flag;
    @(posedge clock) disable iff (rst)
      !gain_legal |=> !gain_in_range;
  endproperty
  a_gain_flag: assert property (p_gain_flag) // [R2]
    else $error("illegal gain not flagged");

  // no disable here: this one watches the reset values themselves
  property p_reset_gain;
    @(posedge clock)
      rst |=> s_q.gain == GAIN_RESET && gain_in_range && !p_control;
  endproperty
  a_reset_gain: assert property (p_reset_gain) // [R2]
    else $error("reset did not restore the default gain");

  property p_ff_sel_off;
    @(posedge clock) disable iff (rst)
      speed_ff_select_field != FF_VREF |=> ff_speed == 0;
  endproperty
  a_ff_sel_off: assert property (p_ff_sel_off) // [R1]
    else $error("feed-forward active with select off");

  property p_ff_sign;
    @(posedge clock) disable iff (rst)
      (ff_en && speed_ain < 0) |=> ff_speed <= 0;
  endproperty
  a_ff_sign: assert property (p_ff_sign) // [R4]
    else $error("feed-forward sign does not follow input");

  property p_pos_pin_low;
    @(posedge clock) disable iff (rst)
      (!prop_only_request_input_n && pos_mode) [*3] |=> p_control;
  endproperty
  a_pos_pin_low: assert property (p_pos_pin_low) // [R6]
    else $error("pin low in position control did not give P");

  property p_pin_other_mode;
    @(posedge clock) disable iff (rst)
      (control_mode_select_field[1] && !auto_hit) |=> !p_control;
  endproperty
  a_pin_other_mode: assert property (p_pin_other_mode) // [R6]
    else $error("pin honoured outside speed or position control");

  property p_accel_trip;
    @(posedge clock) disable iff (rst)
      (sel == SW_ACCEL && over[2]) |=> auto_p_active;
  endproperty
  a_accel_trip: assert property (p_accel_trip) // [R11]
    else $error("accel level did not switch to P");

  property p_error_trip;
    @(posedge clock) disable iff (rst)
      (sel == SW_ERROR && over[3] && pos_mode) |=> auto_p_active;
  endproperty
  a_error_trip: assert property (p_error_trip) // [R12]
    else $error("error level did not switch to P");

  property p_torque_release;
    @(posedge clock) disable iff (rst)
      (sel == SW_TORQUE && !over[0]) |=> !auto_p_active;
  endproperty
  a_torque_release: assert property (p_torque_release) // [R15]
    else $error("torque switch held after level cleared");

  property p_speed_release;
    @(posedge clock) disable iff (rst)
      (sel == SW_SPEED && !over[1]) |=> !auto_p_active;
  endproperty
  a_speed_release: assert property (p_speed_release) // [R15]
    else $error("speed switch held after level cleared");

  property p_sel_unused;
    @(posedge clock) disable iff (rst)
      auto_switch_select_field > 3'h4 |=> !auto_p_active;
  endproperty
  a_sel_unused: assert property (p_sel_unused) // [R8]
    else $error("unused select code switched to P");

endmodule : pi_mode_switch_feedforward

// ---- logic/pi_mode_pkg.sv ----
package pi_mode_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VAL_W    = 16;                 // signed servo quantities
  localparam int GAIN_W   = 12;                 // gain setting width
  localparam int SPEED_W  = 16;                 // speed in rpm

  // ---------------------------------------------------------------
  // setting ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_MIN     = 12'h096;  // 150
  localparam logic [GAIN_W-1:0] GAIN_MAX     = 12'hbb8;  // 3000
  localparam logic [GAIN_W-1:0] GAIN_RESET   = 12'h258;  // 600
  localparam logic [15:0]       TORQUE_LVL_RESET = 16'h00c8; // 200 %
  localparam logic [15:0]       RATED_SPEED_RESET = 16'h0bb8; // rpm

  // analog input scaled: one lsb is 0.01 V (so 6 V reads 600)
  localparam int AIN_W = 16;

  // ---------------------------------------------------------------
  // mode encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FF_OFF   = 2'h0;        // feed-forward disabled
  localparam logic [1:0] FF_VREF  = 2'h1;        // analog speed input used

  localparam logic [1:0] CTRL_SPEED = 2'h0;      // speed control
  localparam logic [1:0] CTRL_POS   = 2'h1;      // position control

  typedef enum logic [2:0] {
    SW_TORQUE = 3'h0,
    SW_SPEED  = 3'h1,
    SW_ACCEL  = 3'h2,
    SW_ERROR  = 3'h3,
    SW_OFF    = 3'h4
  } switch_sel_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic signed [VAL_W-1:0] torque_ref;    // percent of rated torque
    logic signed [VAL_W-1:0] speed_ref;     // rpm
    logic signed [VAL_W-1:0] accel;         // 10 rpm/s
    logic signed [VAL_W-1:0] pos_error;     // reference units
  } servo_values_t;

  typedef struct packed {
    logic [VAL_W-1:0] torque_lvl;
    logic [VAL_W-1:0] speed_lvl;
    logic [VAL_W-1:0] accel_lvl;
    logic [VAL_W-1:0] error_lvl;
  } switch_levels_t;

endpackage : pi_mode_pkg

// ---- logic/pi_ff_scaler.sv ----
`timescale 1ns/1ps
// speed feed-forward: speed = ain * rated / gain, clamped to +-rated
module pi_ff_scaler
  import pi_mode_pkg::*;
(
  input  wire logic                      clock,        // system clock
  input  wire logic                      rst,          // sync reset
  input  wire logic                      enable,       // path active
  input  wire logic signed [AIN_W-1:0]   ain,          // 0.01 V units
  input  wire logic [GAIN_W-1:0]         gain,         // 0.01 V/rated
  input  wire logic [SPEED_W-1:0]        rated_speed,  // rpm
  output logic signed [SPEED_W-1:0]      ff_speed      // rpm, registered
);
  import pi_mode_pkg::*;

  typedef struct packed {
    logic signed [SPEED_W-1:0] ff;
  } state_t;

  state_t s_q, s_d;
  logic        [AIN_W-1:0]   mag;
  logic        [31:0]        prod;
  logic        [31:0]        quo;
  logic        [SPEED_W-1:0] lim;

  // ---------------------------------------------------------------
  // scale and limit
  // ---------------------------------------------------------------
  // combinational divide: costly, but the gain changes take effect at once
  always_comb begin
    s_d  = s_q;
    mag  = ain[AIN_W-1] ? 16'(-ain) : 16'(ain);
    prod = 32'(mag) * 32'(rated_speed);
    quo  = (gain == 12'h000) ? 32'h0000_0000 : prod / 32'(gain); // [R2]
    lim  = (quo > 32'(rated_speed)) ? rated_speed : quo[SPEED_W-1:0]; // [R4]
    if (!enable) begin
      s_d.ff = '0;                                  // [R1] [R3]
    end else if (ain[AIN_W-1]) begin
      s_d.ff = 16'(-$signed({1'b0, lim}));
    end else begin
      s_d.ff = $signed(lim);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ff_speed = s_q.ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ff_limit;
    @(posedge clock) disable iff (rst)
      enable |=> ((ff_speed >= 0 ? ff_speed : -ff_speed)
                  <= $signed({1'b0, $past(rated_speed)}));
  endproperty
  a_ff_limit: assert property (p_ff_limit) // [R4]
    else $error("feed-forward exceeds rated speed");

  property p_ff_off;
    @(posedge clock) disable iff (rst)
      !enable |=> ff_speed == 0;
  endproperty
  a_ff_off: assert property (p_ff_off) // [R1]
    else $error("feed-forward active while disabled");

  property p_ff_rated;
    @(posedge clock) disable iff (rst)
      (enable && ain == 16'sd600 && gain == GAIN_RESET)
        |=> ff_speed == $signed({1'b0, $past(rated_speed)});
  endproperty
  a_ff_rated: assert property (p_ff_rated) // [R4]
    else $error("6 V at default gain is not rated speed");

endmodule : pi_ff_scaler

// ---- logic/pi_level_detect.sv ----
`timescale 1ns/1ps
// magnitude compare: high while |value| exceeds level
module pi_level_detect
  import pi_mode_pkg::*;
#(
  parameter int W = VAL_W                        // value width
) (
  input  wire logic                clock,         // system clock
  input  wire logic                rst,           // sync reset
  input  wire logic signed [W-1:0] value,         // signed quantity
  input  wire logic        [W-1:0] level,         // detection level
  output logic                     over           // registered
);
  import pi_mode_pkg::*;

  typedef struct packed {
    logic over;
  } state_t;

  state_t s_q, s_d;
  logic [W:0] mag;

  // magnitude so deceleration trips as well as acceleration
  always_comb begin
    s_d      = s_q;
    mag      = value[W-1] ? (W+1)'(-{value[W-1], value})
                          : (W+1)'({1'b0, value});
    s_d.over = mag > {1'b0, level};               // [R15]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign over = s_q.over;

endmodule : pi_level_detect

// ---- verif/pi_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host controller: position reference and its slope
// ---------------------------------------------------------------
module pi_host_model
  import pi_mode_pkg::*;
(
  input  wire logic                    clock,     // system clock
  input  wire logic                    rst,       // sync reset
  input  wire logic signed [AIN_W-1:0] vel,       // counts per cycle
  input  wire logic                    p_req,     // host wants P loop
  output logic signed [AIN_W-1:0]      speed_ain, // ff voltage
  output logic                         prop_n     // pin, low = P
);
  logic signed [31:0] pos_q;   // reference sent as pulses
  logic signed [31:0] prev_q;  // previous reference, for the slope

  // slope and pulses leave on one edge, so ff never leads pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      pos_q  <= '0;
      prev_q <= '0;
      prop_n <= 1'b1;
    end else begin
      pos_q  <= pos_q + 32'(vel);
      prev_q <= pos_q;
      prop_n <= ~p_req;
    end
  end

  // differentiated reference onto the analog input
  assign speed_ain = AIN_W'(pos_q - prev_q);
endmodule : pi_host_model

// ---- verif/pi_mode_switch_feedforward_tb_top.sv ----
`timescale 1ns/1ps
module pi_mode_switch_feedforward_tb_top;
  import pi_mode_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, design and host
  // ---------------------------------------------------------------
  logic                      clock;
  logic                      rst;
  logic [1:0]                ff_sel;
  logic [GAIN_W-1:0]         gain;
  logic [1:0]                mode;
  logic [2:0]                sw_sel;
  switch_levels_t            lv;
  servo_values_t             sv;
  logic [SPEED_W-1:0]        rated;
  logic signed [AIN_W-1:0]   vel;
  logic                      p_req;
  logic signed [AIN_W-1:0]   ain;
  logic                      pin_n;
  logic signed [SPEED_W-1:0] ff_speed;
  logic                      p_control;
  logic                      auto_p;
  logic                      gain_ok;
  int                        failures;
  int                        n_tests;
  int                        cycles;
  int                        eff_gain;
  int                        vset [4] = '{-600, 900, -1500, 599};
  int                        gset [7] = '{149, 150, 3000, 3001,
                                          0, 4095, 1200};

  pi_mode_switch_feedforward u_dut (
    .clock(clock), .rst(rst), .speed_ff_select_field(ff_sel),
    .speed_input_gain_setting(gain), .control_mode_select_field(mode),
    .auto_switch_select_field(sw_sel), .levels(lv), .values(sv),
    .rated_speed(rated), .speed_ain(ain),
    .prop_only_request_input_n(pin_n), .ff_speed(ff_speed),
    .p_control(p_control), .auto_p_active(auto_p),
    .gain_in_range(gain_ok));

  pi_host_model u_host (
    .clock(clock), .rst(rst), .vel(vel), .p_req(p_req),
    .speed_ain(ain), .prop_n(pin_n));

  // free-running clock, 20 ns
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard: far above the ~720 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // compare and reference model
  // ---------------------------------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  function automatic bit over(input int v, input int l);
    return ((v < 0) ? -v : v) > l;
  endfunction : over

  // inputs are held five cycles, so every latency has run out
  task automatic check;
    int m;
    int e_ff;
    bit ea;
    bit ok;
    repeat (5) @(posedge clock);
    #1;
    ok = gain >= GAIN_MIN && gain <= GAIN_MAX;
    if (ok) eff_gain = gain;
    m = int'(vel);
    m = (m < 0 ? -m : m) * int'(rated) / eff_gain;
    if (m > int'(rated)) m = rated;
    e_ff = (ff_sel == FF_VREF && mode == CTRL_POS) ? (vel < 0 ? -m : m) : 0;
    case (sw_sel)
      SW_TORQUE: ea = over(sv.torque_ref, lv.torque_lvl);
      SW_SPEED:  ea = over(sv.speed_ref, lv.speed_lvl);
      SW_ACCEL:  ea = over(sv.accel, lv.accel_lvl);
      SW_ERROR:  ea = over(sv.pos_error, lv.error_lvl) && mode == CTRL_POS;
      default:   ea = 1'b0;
    endcase
    cmp_val(ff_speed, SPEED_W'(e_ff));
    cmp_bit(auto_p, ea);
    cmp_bit(p_control, ea | (p_req && mode < 2));
    cmp_bit(gain_ok, ok);
  endtask : check

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hcc72));
    {failures, n_tests, cycles, eff_gain} = {32'd0, 32'd0, 32'd0, 32'd600};
    rst = 1'b1;
    ff_sel = FF_OFF;
    gain = GAIN_RESET;
    mode = CTRL_POS;
    sw_sel = SW_OFF;
    lv = '{TORQUE_LVL_RESET, 16'h0064, 16'h0064, 16'h0064};
    sv = '0;
    rated = RATED_SPEED_RESET;
    vel = '0;
    p_req = 1'b0;
    repeat (15) @(posedge clock);
    #1;
    check();
    rst = 1'b0;
    // every select code against every control mode
    for (int f = 0; f < 4; f++) begin
      for (int md = 0; md < 4; md++) begin
        ff_sel = 2'(f);
        mode = 2'(md);
        vel = 16'sh0258;
        check();
      end
    end
    // sign and clamp at the default gain
    // path switched on, or every compare below would only see zero
    ff_sel = FF_VREF;
    mode = CTRL_POS;
    foreach (vset[i]) begin
      vel = AIN_W'(vset[i]);
      check();
    end
    // gain edges; an illegal value must keep the last legal one
    foreach (gset[i]) begin
      gain = GAIN_W'(gset[i]);
      vel = 16'sh0384;
      check();
    end
    // pin against control mode with the auto switch off
    for (int md = 0; md < 4; md++) begin
      for (int p = 0; p < 2; p++) begin
        mode = 2'(md);
        p_req = p[0];
        check();
      end
    end
    p_req = 1'b0;
    // one above the level, then exactly at it; negatives too
    lv = '{16'h012c, 16'h0190, 16'h0064, 16'h0032};
    for (int k = 0; k < 2; k++) begin
      sv = '{16'(301 - k), 16'(-401 + k), 16'(101 - k), 16'(-51 + k)};
      for (int s = 0; s < 8; s++) begin
        for (int md = 0; md < 4; md++) begin
          sw_sel = 3'(s);
          mode = 2'(md);
          check();
        end
      end
    end
    // two-cycle rise and fall of the auto switch
    sw_sel = SW_TORQUE;
    sv = '0;
    lv.torque_lvl = TORQUE_LVL_RESET;
    check();
    for (int k = 0; k < 2; k++) begin
      sv.torque_ref = k ? 16'sh0000 : 16'sh012c;
      @(posedge clock);
      #1;
      cmp_bit(auto_p, k[0]);
      @(posedge clock);
      #1;
      cmp_bit(auto_p, !k[0]);
    end
    // random mix of every input
    repeat (40) begin
      ff_sel = 2'($urandom_range(3));
      mode = 2'($urandom_range(3));
      sw_sel = 3'($urandom_range(7));
      gain = GAIN_W'($urandom_range(3100, 100));
      rated = SPEED_W'($urandom_range(6000, 500));
      vel = AIN_W'(int'($urandom_range(4000)) - 2000);
      p_req = 1'($urandom_range(1));
      for (int i = 0; i < 4; i++) begin
        lv[i*16 +: 16] = 16'($urandom_range(500));
        sv[i*16 +: 16] = 16'(int'($urandom_range(1200)) - 600);
      end
      check();
    end
    summarize();
  end
endmodule : pi_mode_switch_feedforward_tb_top
